// ### rtl/gss_cfg.svh
// Constants for the global-shutter sensor timing block
`ifndef GSS_CFG_SVH
`define GSS_CFG_SVH

// Clock and reset timing
`define GSS_CLK_MHZ        100
`define GSS_CLK_MAX_MHZ    66
`define GSS_RST_MIN_NS     200
`define GSS_RST_MIN_CYC    ((`GSS_RST_MIN_NS * `GSS_CLK_MHZ + 999) / 1000)
`define GSS_FSYNC_MIN_CYC  2

// Array geometry and pixel word
`define GSS_COLS           659
`define GSS_ROWS           494
`define GSS_PIX_W          10
`define GSS_PIX_MSB        9

// Exposure limits: 2 rows up to 256 frames (shift by 8)
`define GSS_EXP_MIN_ROWS   19'h00002
`define GSS_EXP_FRM_SHIFT  8

// Gain step limits, 1..18 (x1 or x0.5 per step)
`define GSS_GAIN_MIN       5'h01
`define GSS_GAIN_MAX       5'h12

// Pin idle levels after reset: active-low strobes high
`define GSS_PIN_IDLE       7'h7a

`endif

// ### rtl/gss_pkg.sv
// Types shared by the sensor timing block
package gss_pkg;

   // Operating mode
   typedef enum logic [1:0] {
      GSS_MASTER = 2'h0,
      GSS_SNAP   = 2'h1,
      GSS_SLAVE  = 2'h3
   } gss_mode_t;

   // Internal frame sequencer, Gray along the path except the return from VBLANK to IDLE
   typedef enum logic [2:0] {
      GSS_IDLE   = 3'h0,
      GSS_EXPOSURE_PIN = 3'h1,
      GSS_XFER   = 3'h3,
      GSS_ROWS   = 3'h2,
      GSS_VBLANK = 3'h6
   } gss_fst_t;

   // Timing pins as seen after synchronisation
   typedef struct packed {
      logic fsync_n;
      logic memrst_n;
      logic xfer_n;
      logic pdrst_n;
      logic expo;
      logic shld_n;
      logic rowp;
   } gss_pins_t;

   // Window of interest
   typedef struct packed {
      logic [9:0] row_start;
      logic [9:0] row_stop;
      logic [9:0] col_start;
      logic [9:0] col_stop;
   } gss_win_t;

endpackage

// ### rtl/gss_sensor_timing.sv
// Sensor timing, row double buffer and pixel readout
`timescale 1ns/1ns
`include "gss_cfg.svh"
// Behaviour
// R1 - All logic runs from one system clock.
// R2 - Logic reset clears everything; it must be held at least 200 ns. Here reset loads idle pin history, a high shift-load output and gain code 1.
// R3 - Slave row pulse starts conversion of one row into the row registers.
// R4 - Partner drives row pulse high for exactly one clock.
// R5 - Slave shift-load low enables column counter and reads out buffered row.
// R6 - While shift-load low, pixel port takes the next column each clock.
// R7 - Direction of row, shift-load and exposure pins follows a setting.
// R8 - Snapshot exposure starts from the exposure pin used as input.
// R9 - Slave photodiode-reset pulse resets all detectors, starting integration.
// R10 - Slave charge-transfer pulse moves all pixel charge into pixel memory.
// R11 - Slave memory-reset pulse clears all pixel memories.
// R12 - Partner leaves slave strobes open in master and snapshot modes.
// R13 - Master and snapshot exposure spans 2 rows up to 256 frames.
// R14 - Gain 1x-18x in unit steps or 0.5x-9x in half steps.
// R15 - Master times itself, snapshot waits for trigger, slave follows inputs.
// R16 - Integration from setting in master/snapshot, from strobes in slave.
// R17 - Scan limited to programmable start/stop row and column window.
// R18 - Rows scanned progressively or interlaced by a selection.
// R19 - Horizontal and vertical blanking set row and frame rate.
// R20 - Converted row moves to output memory; next row converts meanwhile.
// R21 - Per-column calibration coefficients self-learned, readable and writable.
// R22 - Pixels leave as 10-bit words, one per clock during readout.
// R23 - Slave frame sync low resets counters and holds standby; low two clocks.
// R24 - Line valid high whenever valid pixels are on the port.
// R25 - Pixel msb on output bit 9, lower bits on 8 to 0.
// R26 - Pixel port holds its last value outside readout.
module gss_sensor_timing
   import gss_pkg::*;
#(
   parameter int COLS = `GSS_COLS,
   parameter int PW   = `GSS_PIX_W
) (
   // Clock and reset
   input  logic         clk,
   input  logic         srst,
   // Configuration
   input  gss_mode_t    mode,
   input  logic [2:0]   pin_dir,
   input  gss_win_t     win,
   input  logic         interlace,
   input  logic [9:0]   hblank,
   input  logic [9:0]   vblank,
   input  logic [18:0]  exp_rows,
   input  logic         gain_half,
   input  logic [4:0]   gain_step,
   // Timing pins, inputs
   input  logic         row_process_pulse_i,
   input  logic         column_shift_load_n_i,
   input  logic         exposure_pin_i,
   input  logic         photodiode_reset_n,
   input  logic         charge_transfer_n,
   input  logic         pixel_memory_reset_n,
   input  logic         frame_sync_n,
   // Timing pins, drive side
   output logic         row_process_pulse_o,
   output logic         row_process_pulse_oe,
   output logic         column_shift_load_n_o,
   output logic         column_shift_load_n_oe,
   output logic         exposure_pin_o,
   output logic         exposure_pin_oe,
   // Column converters
   output logic         conv_start,
   output logic [9:0]   conv_row,
   input  logic         conv_valid,
   input  logic [9:0]   conv_col,
   input  logic [PW-1:0] conv_data,
   input  logic         conv_done,
   // Calibration coefficients
   input  logic         cal_run,
   input  logic         cal_we,
   input  logic [9:0]   cal_addr,
   input  logic [PW-1:0] cal_wdata,
   output logic [PW-1:0] cal_rdata,
   // Pixel array strobes and gain
   output logic         array_pd_reset,
   output logic         array_xfer,
   output logic         array_mem_reset,
   output logic [4:0]   pga_code,
   output logic         pga_half,
   // Video out
   output logic [PW-1:0] pixel_out,
   output logic         line_valid,
   output logic         frame_valid,
   output logic         standby
);
   typedef struct packed {
      gss_pins_t             prev;
      gss_fst_t              fst;
      logic [9:0]            row;
      logic                  field;
      logic [10:0]           rcnt;
      logic [9:0]            bcnt;
      logic [18:0]           ecnt;
      logic                  conv_start;
      logic [9:0]            conv_row;
      logic [COLS-1:0][PW-1:0] row_mem;
      logic [COLS-1:0][PW-1:0] out_mem;
      logic [COLS-1:0][PW-1:0] cal_mem;
      logic                  row_ready;
      logic                  rd_act;
      logic [9:0]            col;
      logic [PW-1:0]         pixel;
      logic                  lv;
      logic                  fv;
      logic                  pd;
      logic                  xf;
      logic                  mr;
      logic                  rp_o;
      logic                  shld_o_n;
      logic                  expo_o;
      logic [2:0]            oe;
      logic [PW-1:0]         cal_rdata;
      logic [4:0]            pga_code;
      logic                  pga_half;
      logic                  standby;
   } gss_st_t;

   gss_st_t   s_r;
   gss_st_t   s_nxt;
   gss_pins_t pin_raw;
   gss_pins_t pin_s;

   // R1 single clock
   // Every pin from the partner is resynchronised first
   assign pin_raw = '{fsync_n: frame_sync_n, memrst_n: pixel_memory_reset_n,
                      xfer_n: charge_transfer_n, pdrst_n: photodiode_reset_n,
                      expo: exposure_pin_i, shld_n: column_shift_load_n_i,
                      rowp: row_process_pulse_i};

   gss_sync2 #(
      .W   (7),
      .RST (`GSS_PIN_IDLE)
   ) u_sync (
      .clk  (clk),
      .srst (srst),
      .d    (pin_raw),
      .q    (pin_s)
   );

   logic         slave;
   logic         rp_rise;
   logic         sl_act;
   logic         sl_end;
   logic         ex_rise;
   logic         pd_fall;
   logic         xf_fall;
   logic         mr_fall;
   logic         fs_low;
   logic         tick;
   logic         rd_now;
   logic         rwrap;
   logic [9:0]   radv;
   logic [10:0]  rperiod;
   logic [10:0]  frows;
   logic [18:0]  emax;
   logic [18:0]  eset;
   logic [PW-1:0] rd_word;
   logic [PW-1:0] cal_word;

   // R4 one-clock pulse seen as one rising edge
   // R7 a pin is read only while set as input, except the shift-load end edge
   assign slave   = mode == GSS_SLAVE;
   assign rp_rise = pin_s.rowp & ~s_r.prev.rowp & ~pin_dir[0];
   assign sl_act  = ~pin_s.shld_n & ~pin_dir[1];
   assign sl_end  = pin_s.shld_n & ~s_r.prev.shld_n;
   assign ex_rise = pin_s.expo & ~s_r.prev.expo & ~pin_dir[2];
   assign pd_fall = ~pin_s.pdrst_n & s_r.prev.pdrst_n;
   assign xf_fall = ~pin_s.xfer_n & s_r.prev.xfer_n;
   assign mr_fall = ~pin_s.memrst_n & s_r.prev.memrst_n;
   assign fs_low  = ~pin_s.fsync_n;
   assign rd_now  = slave ? sl_act : s_r.rd_act;
   assign rd_word = s_r.out_mem[s_r.col];
   assign cal_word = s_r.cal_mem[conv_col];

   // R19 row period is window width plus blanking
   assign rperiod = {1'b0, win.col_stop} - {1'b0, win.col_start} + 11'h001 + {1'b0, hblank};
   assign tick    = s_r.rcnt == rperiod - 11'h001;
   assign frows   = {1'b0, win.row_stop} - {1'b0, win.row_start} + 11'h001 + {1'b0, vblank};
   assign emax    = {frows, 8'h00};

   // R13 exposure clamped to 2 rows .. 256 frames
   assign eset = (exp_rows < `GSS_EXP_MIN_ROWS) ? `GSS_EXP_MIN_ROWS :
                 (exp_rows > emax) ? emax : exp_rows;

   // R18 step of one or two rows, second field odd
   assign radv  = s_r.row + (interlace ? 10'h002 : 10'h001);
   assign rwrap = radv > win.row_stop;

   // Next-state logic
   always_comb begin
      s_nxt            = s_r;
      s_nxt.prev       = pin_s;
      s_nxt.conv_start = 1'b0;
      s_nxt.rp_o       = 1'b0;
      s_nxt.pd         = 1'b0;
      s_nxt.xf         = 1'b0;
      s_nxt.mr         = 1'b0;
      s_nxt.lv         = 1'b0;
      s_nxt.standby    = 1'b0;
      // R7 pin direction
      s_nxt.oe         = pin_dir;
      // R14 gain code clamp, half range halves each step
      s_nxt.pga_half   = gain_half;
      s_nxt.pga_code   = (gain_step < `GSS_GAIN_MIN) ? `GSS_GAIN_MIN :
                         (gain_step > `GSS_GAIN_MAX) ? `GSS_GAIN_MAX : gain_step;
      s_nxt.rcnt       = (tick || s_r.fst == GSS_IDLE) ? 11'h000 : s_r.rcnt + 11'h001;

      // R21 calibration pass learns offsets, else subtract them
      if (conv_valid && conv_col < COLS) begin
         if (cal_run) begin
            s_nxt.cal_mem[conv_col] = conv_data;
         end else begin
            s_nxt.row_mem[conv_col] = (conv_data > cal_word) ? conv_data - cal_word : '0;
         end
      end
      if (conv_done && !cal_run) begin
         s_nxt.row_ready = 1'b1;
      end
      // R21 coefficient access; later write wins on same column
      if (cal_we && cal_addr < COLS) begin
         s_nxt.cal_mem[cal_addr] = cal_wdata;
      end
      s_nxt.cal_rdata = s_r.cal_mem[cal_addr];

      // Readout of the buffered row
      if (slave) begin
         // R5 shift-load enables column counter
         // R6 next column each rising edge
         if (sl_act) begin
            s_nxt.pixel = rd_word;
            s_nxt.lv    = 1'b1;
            if (s_r.col != win.col_stop) begin
               s_nxt.col = s_r.col + 10'h001;
            end
         end else if (sl_end) begin
            s_nxt.col = win.col_start;
         end
      end else if (s_r.rd_act) begin
         // R22 one word per clock
         s_nxt.pixel = rd_word;
         s_nxt.lv    = 1'b1;
         if (s_r.col == win.col_stop) begin
            s_nxt.rd_act = 1'b0;
         end else begin
            s_nxt.col = s_r.col + 10'h001;
         end
      end

      // R20 swap only between readouts so a row never tears
      if (s_r.row_ready && !rd_now) begin
         s_nxt.out_mem   = s_r.row_mem;
         s_nxt.row_ready = conv_done && !cal_run; // Row finishing now stays pending
         s_nxt.col       = win.col_start;
         s_nxt.rd_act    = !slave;
      end

      if (slave) begin
         // R15 slave follows external timing only
         s_nxt.fst = GSS_IDLE;
         // R16 integration set by strobes
         // R9 detector reset
         s_nxt.pd  = pd_fall;
         // R10 charge transfer
         s_nxt.xf  = xf_fall;
         // R11 memory clear
         s_nxt.mr  = mr_fall;
         // R23 frame sync resets counters, standby while low
         if (fs_low) begin
            s_nxt.row     = win.row_start;
            s_nxt.col     = win.col_start;
            s_nxt.field   = 1'b0;
            s_nxt.standby = 1'b1;
         end else if (rp_rise) begin
            // R3 one row conversion per pulse
            s_nxt.conv_start = 1'b1;
            s_nxt.conv_row   = s_r.row;
            s_nxt.row        = rwrap ? win.row_start + {9'h000, interlace & ~s_r.field} : radv;
            s_nxt.field      = rwrap ? interlace & ~s_r.field : s_r.field;
         end
      end else begin
         // R15 internal frame sequencer
         case (s_r.fst)
            GSS_IDLE: begin
               // R8 snapshot waits for trigger
               if (mode == GSS_MASTER || (mode == GSS_SNAP && ex_rise)) begin
                  s_nxt.fst  = GSS_EXPOSURE_PIN;
                  s_nxt.pd   = 1'b1;
                  s_nxt.mr   = 1'b1;
                  // R16 integration from setting
                  s_nxt.ecnt = eset;
               end
            end
            GSS_EXPOSURE_PIN: begin
               // R13 count exposure in rows
               if (tick) begin
                  if (s_r.ecnt <= 19'h00001) begin
                     s_nxt.fst = GSS_XFER;
                  end else begin
                     s_nxt.ecnt = s_r.ecnt - 19'h00001;
                  end
               end
            end
            GSS_XFER: begin
               s_nxt.xf    = 1'b1;
               // R17 start at window top
               s_nxt.row   = win.row_start;
               s_nxt.field = 1'b0;
               s_nxt.rcnt  = 11'h000;
               s_nxt.fst   = GSS_ROWS;
            end
            GSS_ROWS: begin
               if (s_r.rcnt == 11'h000) begin
                  s_nxt.conv_start = 1'b1;
                  s_nxt.conv_row   = s_r.row;
                  s_nxt.rp_o       = 1'b1;
               end
               // R17 R18 advance within window
               if (tick) begin
                  if (rwrap && !(interlace && !s_r.field)) begin
                     s_nxt.fst  = GSS_VBLANK;
                     s_nxt.bcnt = vblank;
                  end else if (rwrap) begin
                     s_nxt.row   = win.row_start + 10'h001;
                     s_nxt.field = 1'b1;
                  end else begin
                     s_nxt.row = radv;
                  end
               end
            end
            GSS_VBLANK: begin
               // R19 vertical blanking in rows
               if (s_r.bcnt == 10'h000) begin
                  s_nxt.fst = GSS_IDLE;
               end else if (tick) begin
                  s_nxt.bcnt = s_r.bcnt - 10'h001;
               end
            end
            default: s_nxt.fst = GSS_IDLE;
         endcase
      end

      // R24 frame and line valid for master/snapshot
      s_nxt.expo_o   = s_nxt.fst == GSS_EXPOSURE_PIN;
      s_nxt.fv       = !slave && (s_nxt.fst == GSS_ROWS || s_r.rd_act || s_nxt.rd_act || s_nxt.row_ready);
      s_nxt.shld_o_n = ~s_nxt.lv;
   end

   // R2 reset clears all state but pin history, shift-load output and gain code
   always_ff @(posedge clk) begin
      if (srst) begin
         s_r <= '{prev: `GSS_PIN_IDLE, fst: GSS_IDLE, shld_o_n: 1'b1, pga_code: `GSS_GAIN_MIN, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // R25 msb on bit 9, straight from flops
   assign pixel_out              = s_r.pixel;
   assign line_valid             = s_r.lv;
   assign frame_valid            = s_r.fv;
   assign standby                = s_r.standby;
   assign conv_start             = s_r.conv_start;
   assign conv_row               = s_r.conv_row;
   assign cal_rdata              = s_r.cal_rdata;
   assign array_pd_reset         = s_r.pd;
   assign array_xfer             = s_r.xf;
   assign array_mem_reset        = s_r.mr;
   assign pga_code               = s_r.pga_code;
   assign pga_half               = s_r.pga_half;
   assign row_process_pulse_o    = s_r.rp_o;
   assign row_process_pulse_oe   = s_r.oe[0];
   assign column_shift_load_n_o  = s_r.shld_o_n;
   assign column_shift_load_n_oe = s_r.oe[1];
   assign exposure_pin_o         = s_r.expo_o;
   assign exposure_pin_oe        = s_r.oe[2];

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_slave_pd;  slave && pd_fall; endsequence
   sequence s_slave_xf;  slave && xf_fall; endsequence
   sequence s_slave_mr;  slave && mr_fall; endsequence
   sequence s_exp_end;   s_r.fst == GSS_EXPOSURE_PIN && tick && s_r.ecnt == 19'h00001; endsequence

   // R3 row pulse starts conversion
   a_slave_row_start: assert property (slave && rp_rise && !fs_low |=> conv_start) // R3
      else $error("row pulse did not start conversion");
   // R5 column counter steps
   a_shift_col_step: assert property (slave && sl_act && !fs_low && s_r.col != win.col_stop
                                      |=> s_r.col == $past(s_r.col) + 10'h001) // R5
      else $error("column counter did not step");
   // R6 port takes buffered word
   a_shift_pix_out: assert property (slave && sl_act |=> line_valid && pixel_out == $past(rd_word)) // R6
      else $error("pixel port not updated");
   // R26 hold outside readout
   a_pixel_hold: assert property (!rd_now |=> $stable(pixel_out)) // R26
      else $error("pixel port moved outside readout");
   // R7 direction follows setting
   a_pin_dir: assert property (1'b1 |=> {exposure_pin_oe, column_shift_load_n_oe, row_process_pulse_oe}
                                        == $past(pin_dir)) // R7
      else $error("pin direction wrong");
   // R8 snapshot trigger
   a_snap_trigger: assert property (mode == GSS_SNAP && s_r.fst == GSS_IDLE && ex_rise
                                    |=> exposure_pin_o ##1 exposure_pin_o) // R8
      else $error("snapshot trigger missed");
   // R9 detector reset
   a_pd_reset: assert property (s_slave_pd |=> array_pd_reset) // R9
      else $error("photodiode reset not forwarded");
   // R10 charge transfer
   a_xfer_strobe: assert property (s_slave_xf |=> array_xfer) // R10
      else $error("charge transfer not forwarded");
   // R11 memory reset
   a_mem_reset: assert property (s_slave_mr |=> array_mem_reset) // R11
      else $error("memory reset not forwarded");
   // R13 exposure ends into transfer
   a_exposure_pin_end: assert property (((!slave) and s_exp_end) |=> s_r.fst == GSS_XFER ##1 array_xfer) // R13
      else $error("exposure did not end on count");
   // R23 standby under frame sync
   a_frame_sync: assert property (slave && fs_low |=> standby && s_r.field == 1'b0) // R23
      else $error("frame sync not honoured");
   // R24 line valid inside frame valid
   a_line_valid: assert property (!slave && line_valid |-> frame_valid) // R24
      else $error("line valid outside frame");
   // R14 gain code range
   a_gain_range: assert property (1'b1 |=> pga_code >= 5'h01 && pga_code <= 5'h12) // R14
      else $error("gain code out of range");
endmodule

// ### rtl/gss_sync2.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module gss_sync2 #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input  logic         clk,
   input  logic         srst,
   // Data
   input  logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } gss_sync_t;

   gss_sync_t s_r;
   gss_sync_t s_nxt;

   // First stage feeds only the second
   always_comb begin
      s_nxt.meta = d;
      s_nxt.stab = s_r.meta;
   end

   // Register both stages
   always_ff @(posedge clk) begin
      if (srst) begin
         s_r <= {RST, RST};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.stab;
endmodule

// ### test/gss_ctl_model.sv
// Behavioural outside timing controller for slave mode
`timescale 1ns/1ns
module gss_ctl_model (
   // Clock
   input  logic clk,
   // Slave timing pins
   output logic rowp,
   output logic shld_n,
   output logic pdrst_n,
   output logic xfer_n,
   output logic memrst_n,
   output logic fsync_n,
   output logic expo
);
   // exposure pin left idle in slave
   initial begin
      rowp = 1'b0;
      expo = 1'b0;
      {shld_n, pdrst_n, xfer_n, memrst_n, fsync_n} = 5'h1f;
   end

   // edges land on falling clock edge
   // Index: 0 pd, 1 xfer, 2 mem, 3 sync, 4 shift, 5 row
   task automatic pin(input int k, input logic v);
      @(negedge clk);
      case (k)
         0: pdrst_n = v;
         1: xfer_n = v;
         2: memrst_n = v;
         3: fsync_n = v;
         4: shld_n = v;
         default: rowp = v;
      endcase
   endtask
endmodule

// ### test/tb.sv
// Self-checking bench for the sensor timing block in slave and master modes
`timescale 1ns/1ns
module tb;
   import gss_pkg::*;
   logic         clk, srst, interlace, gain_half, conv_valid, conv_done, cal_run, cal_we;
   gss_mode_t    mode;
   gss_win_t     win;
   logic [2:0]   pin_dir, strb;
   logic [9:0]   hblank, vblank, conv_col, conv_data, cal_addr, cal_wdata, cw, conv_row, cal_rdata;
   logic [9:0]   pixel_out, rowd [16];
   logic [18:0]  exp_rows;
   logic [4:0]   gain_step, g, pga_code;
   logic         rowp, shld_n, expo, photodiode_reset_n, charge_transfer_n, pixel_memory_reset_n;
   logic         frame_sync_n, conv_start, array_pd_reset, array_xfer, array_mem_reset, pga_half;
   logic         line_valid, standby, column_shift_load_n_o, rpoe, sloe, epoe, rpo, epo, fv;
   int           seed, fails, num_checks, n;

   gss_ctl_model ctl (.clk, .rowp, .shld_n, .pdrst_n(photodiode_reset_n), .xfer_n(charge_transfer_n),
      .memrst_n(pixel_memory_reset_n), .fsync_n(frame_sync_n), .expo);

   gss_sensor_timing #(.COLS(16)) DUT (.clk, .srst, .mode, .pin_dir, .win, .interlace, .hblank,
      .vblank, .exp_rows, .gain_half, .gain_step, .row_process_pulse_i(rowp),
      .column_shift_load_n_i(shld_n), .exposure_pin_i(expo), .photodiode_reset_n, .charge_transfer_n,
      .pixel_memory_reset_n, .frame_sync_n, .row_process_pulse_o(rpo), .row_process_pulse_oe(rpoe),
      .column_shift_load_n_o, .column_shift_load_n_oe(sloe), .exposure_pin_o(epo),
      .exposure_pin_oe(epoe), .conv_start, .conv_row, .conv_valid, .conv_col, .conv_data, .conv_done,
      .cal_run, .cal_we, .cal_addr, .cal_wdata, .cal_rdata, .array_pd_reset, .array_xfer,
      .array_mem_reset, .pga_code, .pga_half, .pixel_out, .line_valid, .frame_valid(fv), .standby);

   assign strb = {array_mem_reset, array_xfer, array_pd_reset};

   // Free-running system clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Gain step clamps to 1..18
   function automatic logic [4:0] exp_gain(input logic [4:0] s);
      return (s < 5'h01) ? 5'h01 : (s > 5'h12) ? 5'h12 : s;
   endfunction

   // Exposure in clocks: at least 2 rows, each row window width plus blanking
   function automatic int exp_cyc(input logic [18:0] r, input logic [9:0] hb);
      return ((r < 19'h00002) ? 2 : int'(r)) * (int'(win.col_stop) - int'(win.col_start) + 1 + int'(hb));
   endfunction

   // Converter results for window columns 2..5, then row done
   task automatic feed_row();
      for (int c = 2; c < 6; c++) begin
         @(posedge clk);
         rowd[c] = 10'($random(seed));
         conv_valid <= 1'b1;
         conv_col <= 10'(c);
         conv_data <= rowd[c];
      end
      @(posedge clk);
      conv_valid <= 1'b0;
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
   endtask

   // One buffered row leaves one word per clock
   task automatic chk_line();
      for (int c = 2; c < 6; c++) begin
         @(posedge clk);
         #1;
         chk_v("pixel_out", rowd[c], pixel_out);
         chk_b("line_valid", 1'b1, line_valid);
      end
   endtask

   task automatic chk_v(input string n, input logic [9:0] e, input logic [9:0] v);
      num_checks++;
      if (v !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, v);
      end
   endtask

   task automatic chk_b(input string n, input logic e, input logic v);
      num_checks++;
      if (v !== e) begin
         fails++;
         $display("wrong value %s expected %b seen %b", n, e, v);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Hang guard, far beyond the roughly 150 cycles needed
   initial begin
      #100000;
      fails++;
      wrap_up();
   end

   // Main sequence
   initial begin
      seed = 42;
      fails = 0;
      num_checks = 0;
      srst = 1'b1;
      mode = GSS_SLAVE;
      pin_dir = 3'h0;
      interlace = 1'b0;
      cal_run = 1'b0;
      win = '{10'h003, 10'h006, 10'h002, 10'h005};
      hblank = 10'($random(seed));
      vblank = 10'($random(seed));
      exp_rows = 19'($random(seed));
      {gain_half, gain_step, conv_valid, conv_done, cal_we} = '0;
      {conv_col, conv_data, cal_addr, cal_wdata} = '0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      chk_v("pixel_out", 10'h000, pixel_out);
      chk_b("line_valid", 1'b0, line_valid);
      chk_b("shift_load_o", 1'b1, column_shift_load_n_o);
      // Gain corners then random steps
      for (int i = 0; i < 8; i++) begin
         g = (i == 0) ? 5'h00 : (i == 1) ? 5'h13 : 5'($random(seed));
         @(posedge clk);
         gain_step <= g;
         gain_half <= i[0];
         repeat (3) @(posedge clk);
         #1;
         chk_v("pga_code", 10'(exp_gain(g)), 10'(pga_code));
         chk_b("pga_half", i[0], pga_half);
      end
      // Each array strobe: one-cycle pulse three edges after the pin
      for (int k = 0; k < 3; k++) begin
         ctl.pin(k, 1'b0);
         ctl.pin(k, 1'b1);
         repeat (2) @(posedge clk);
         #1;
         chk_b("strobe", 1'b1, strb[k]);
         @(posedge clk);
         #1;
         chk_b("strobe end", 1'b0, strb[k]);
      end
      // Frame sync: standby while low, counters back to window start
      ctl.pin(3, 1'b0);
      repeat (3) @(posedge clk);
      #1;
      chk_b("standby", 1'b1, standby);
      ctl.pin(3, 1'b1);
      repeat (3) @(posedge clk);
      #1;
      chk_b("standby", 1'b0, standby);
      // Coefficient outside the window, so pixel data stay raw
      cw = 10'($random(seed));
      @(posedge clk);
      cal_we <= 1'b1;
      cal_addr <= 10'h00c;
      cal_wdata <= cw;
      @(posedge clk);
      cal_we <= 1'b0;
      @(posedge clk);
      #1;
      chk_v("cal_rdata", cw, cal_rdata);
      // Row pulse starts conversion of the first window row
      ctl.pin(5, 1'b1);
      ctl.pin(5, 1'b0);
      repeat (2) @(posedge clk);
      #1;
      chk_b("conv_start", 1'b1, conv_start);
      chk_v("conv_row", win.row_start, conv_row);
      feed_row();
      repeat (4) @(posedge clk);
      // Shift-load readout, one word per clock
      ctl.pin(4, 1'b0);
      repeat (2) @(posedge clk);
      chk_line();
      ctl.pin(4, 1'b1);
      repeat (3) @(posedge clk);
      #1;
      chk_b("line_valid", 1'b0, line_valid);
      chk_v("pixel_out", rowd[5], pixel_out);
      // Pin directions to output
      @(posedge clk);
      pin_dir <= 3'h7;
      repeat (2) @(posedge clk);
      #1;
      chk_v("pin oe", 10'h007, 10'({epoe, sloe, rpoe}));
      // Mid-run reset into master mode, short random exposure and horizontal blanking
      @(posedge clk);
      srst <= 1'b1;
      mode <= GSS_MASTER;
      hblank <= 10'($random(seed)) & 10'h003;
      exp_rows <= 19'($random(seed)) & 19'h00003;
      interlace <= 1'($random(seed));
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      chk_v("pixel_out", 10'h000, pixel_out);
      chk_v("strobes", 10'h005, 10'(strb));
      // Count clocks with the exposure output high
      n = 0;
      while (epo === 1'b1 && n < 500) begin
         n++;
         @(posedge clk);
         #1;
      end
      chk_v("exposure", 10'(exp_cyc(exp_rows, hblank)), 10'(n));
      @(posedge clk);
      #1;
      chk_b("array_xfer", 1'b1, array_xfer);
      @(posedge clk);
      #1;
      chk_b("row pulse out", 1'b1, rpo);
      chk_v("conv_row", win.row_start, conv_row);
      feed_row();
      @(posedge clk);
      chk_line();
      chk_b("frame_valid", 1'b1, fv);
      wrap_up();
   end
endmodule
